// ### rtl/bbe_cfg.svh
`ifndef BBE_CFG_SVH
`define BBE_CFG_SVH
// ***************************
// register map
// ***************************
`define BBE_OFS_CTRL   8'h00
`define BBE_OFS_STAT   8'h04
`define BBE_OFS_BLANK  8'h08
`define BBE_CTRL_RST   1'b0
// ***************************
// switch bit positions
// ***************************
`define BBE_SW_REDRES_A 1
`define BBE_SW_TL_A     2
`define BBE_SW_REDRES_B 3
`define BBE_SW_TL_B     4
// ***************************
// timing
// ***************************
`define BBE_CLK_NS     4
`define BBE_MS_NS      1000000
`define BBE_MS_CYCLES  (`BBE_MS_NS / `BBE_CLK_NS)
`define BBE_TEACH_MS   600000
`define BBE_RST_MIN_MS 250
`define BBE_RST_MAX_MS 2000
`define BBE_BLINK_MS   250
`endif

// ### rtl/bbe_pkg.sv
package bbe_pkg;
	typedef enum logic [2:0] {ST_START, ST_RUN, ST_BLOCK, ST_LATCH, ST_TEACH, ST_DONE, ST_LOCK} bbe_state_e;
	typedef enum logic [1:0] {DISP_COUNT, DISP_TEACH_ACT, DISP_TEACH_DONE, DISP_OFF} bbe_disp_e;
endpackage

// ### rtl/bbe_top.sv
// Functional notes
// - reduced resolution tolerates two adjacent blocked beams
// - reduced resolution flashes green status in run
// - blanked zones flash green
// - unblocked blanked beam forces lockout
// - separate blanked areas need unblanked beam between; teach stores the mask without checking this
// - sync beam never blanked
// - outputs on only while blanked beams blocked
// - teach session over time limit locks out
// - teach entered at power-up or valid reset
// - teach display, zones live, reset off, red
// - normal switches store blanking, show done
// - after teach, resume only via reset
// - teach with clear beams disables blanking
// - trip mode follows interruption automatically
// - latch holds red, reset indicator flashes clear
// - zone red marks each interrupted beam that is not blanked
// - sync beam blocked shows only zone one
// - latch outputs on after clear and reset
`timescale 1ns/1ns
`include "bbe_cfg.svh"
module bbe_top import bbe_pkg::*; #(
	parameter int          N_BEAMS   = 16,
	parameter int          N_ZONES   = 4,
	parameter int unsigned MS_CYCLES = `BBE_MS_CYCLES,
	parameter int          CW        = $clog2(N_BEAMS + 1)
) (
	input  wire logic                 REF_CLK,
	input  wire logic                 RESET,
	input  wire logic [N_BEAMS-1:0]   BEAM_BLOCKED,
	input  wire logic [5:0]           DIP_SW,
	input  wire logic                 RESET_SW,
	input  wire logic                 HSEL,
	input  wire logic [31:0]          HADDR,
	input  wire logic [1:0]           HTRANS,
	input  wire logic                 HWRITE,
	input  wire logic [2:0]           HSIZE,
	input  wire logic [31:0]          HWDATA,
	input  wire logic                 HREADY,
	output logic                      HREADYOUT,
	output logic [31:0]               HRDATA,
	output logic                      HRESP,
	output logic                      SAFETY_OUT_A,
	output logic                      SAFETY_OUT_B,
	output logic                      STATUS_GREEN,
	output logic                      STATUS_RED,
	output logic                      RESET_LED,
	output logic [N_ZONES-1:0]        ZONE_GREEN,
	output logic [N_ZONES-1:0]        ZONE_RED,
	output bbe_disp_e                 DISP_MODE,
	output logic [CW-1:0]             DISP_COUNT
);
	localparam int         BPZ       = N_BEAMS / N_ZONES;
	localparam logic [17:0] MS_LAST  = 18'(MS_CYCLES - 1);
	localparam logic [19:0] TEACH_LIM = 20'(`BBE_TEACH_MS);
	localparam logic [11:0] RST_MIN  = 12'(`BBE_RST_MIN_MS);
	localparam logic [11:0] RST_MAX  = 12'(`BBE_RST_MAX_MS);
	localparam logic [8:0]  BLINK_LAST = 9'(`BBE_BLINK_MS - 1);
	bbe_state_e             st_reg, st_next;
	logic [N_BEAMS-1:0]     mask_reg;
	logic [N_BEAMS-1:0]     eff;
	logic [N_BEAMS+1:0]     pad;
	logic [N_BEAMS-1:0]     bad;
	logic                   bad_any, viol, red_res, trip, teach_pat, norm_pat;
	logic [CW-1:0]          cnt;
	logic [17:0]            div_reg;
	logic                   ms_tick;
	logic [8:0]             blink_cnt_reg;
	logic                   blink_reg;
	logic [19:0]            tmr_reg;
	logic [11:0]            press_reg;
	logic                   sw_q_reg, rst_ok;
	logic [N_ZONES-1:0]     zr, zm;
	logic                   ctrl_inhibit_reg, wr_pend_reg;
	logic [7:0]             wa_reg;

	// ***************************
	// switch decode
	// ***************************
	assign red_res   = DIP_SW[`BBE_SW_REDRES_A];
	assign trip      = DIP_SW[`BBE_SW_TL_A];
	assign teach_pat = DIP_SW[`BBE_SW_REDRES_A] & DIP_SW[`BBE_SW_TL_A]
		& ~DIP_SW[`BBE_SW_REDRES_B] & ~DIP_SW[`BBE_SW_TL_B];
	assign norm_pat  = (DIP_SW[`BBE_SW_REDRES_A] == DIP_SW[`BBE_SW_REDRES_B])
		& (DIP_SW[`BBE_SW_TL_A] == DIP_SW[`BBE_SW_TL_B]);

	// ***************************
	// beam evaluation
	// ***************************
	assign eff = BEAM_BLOCKED & ~mask_reg;
	assign pad = {1'b0, eff, 1'b0};
	assign bad[0] = BEAM_BLOCKED[0];
	for (genvar i = 1; i < N_BEAMS; i++) begin : g_beam
		assign bad[i] = eff[i] & (~red_res | (pad[i] & pad[i+2]));
	end
	assign bad_any = |bad;
	assign viol    = |(mask_reg & ~BEAM_BLOCKED);
	for (genvar z = 0; z < N_ZONES; z++) begin : g_zone
		assign zr[z] = |eff[z*BPZ +: BPZ];
		assign zm[z] = |mask_reg[z*BPZ +: BPZ];
	end
	always_comb begin
		cnt = '0;
		for (int i = 0; i < N_BEAMS; i++) begin
			cnt = cnt + CW'(BEAM_BLOCKED[i]);
		end
	end

	// ***************************
	// time base and blink
	// ***************************
	assign ms_tick = (div_reg == MS_LAST);
	always_ff @(posedge REF_CLK) begin
		if (RESET || ms_tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 18'h00001;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b0;
		end else if (ms_tick) begin
			if (blink_cnt_reg == BLINK_LAST) begin
				blink_cnt_reg <= '0;
				blink_reg     <= ~blink_reg;
			end else begin
				blink_cnt_reg <= blink_cnt_reg + 9'h001;
			end
		end
	end

	// ***************************
	// reset contact timing
	// ***************************
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			sw_q_reg  <= 1'b0;
			press_reg <= '0;
		end else begin
			sw_q_reg <= RESET_SW;
			if (!RESET_SW) begin
				press_reg <= '0;
			end else if (ms_tick && press_reg <= RST_MAX) begin
				press_reg <= press_reg + 12'h001;
			end
		end
	end
	assign rst_ok = sw_q_reg & ~RESET_SW & (press_reg >= RST_MIN) & (press_reg <= RST_MAX);

	// ***************************
	// teach timer
	// ***************************
	always_ff @(posedge REF_CLK) begin
		if (RESET || st_reg != ST_TEACH) begin
			tmr_reg <= '0;
		end else if (ms_tick && tmr_reg < TEACH_LIM) begin
			tmr_reg <= tmr_reg + 20'h00001;
		end
	end

	// ***************************
	// operating state
	// ***************************
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_START, ST_LOCK: begin
				if (st_reg == ST_START || rst_ok) begin
					if (teach_pat) st_next = ST_TEACH;
					else if (!norm_pat) st_next = ST_LOCK;
					else st_next = trip ? ST_RUN : ST_LATCH;
				end
			end
			ST_TEACH: begin
				if (tmr_reg >= TEACH_LIM) st_next = ST_LOCK;
				else if (norm_pat) st_next = ST_DONE;
			end
			ST_DONE: begin
				if (rst_ok) st_next = trip ? ST_RUN : ST_LATCH;
			end
			ST_RUN, ST_BLOCK: begin
				if (viol || !norm_pat) st_next = ST_LOCK;
				else if (!trip) st_next = bad_any ? ST_LATCH : st_reg;
				else st_next = bad_any ? ST_BLOCK : ST_RUN;
			end
			ST_LATCH: begin
				if (viol || !norm_pat) st_next = ST_LOCK;
				else if (rst_ok && !bad_any) st_next = ST_RUN;
			end
			default: st_next = ST_LOCK;
		endcase
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			st_reg <= ST_START;
		end else begin
			st_reg <= st_next;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			mask_reg <= '0;
		end else if (st_next == ST_TEACH && st_reg != ST_TEACH) begin
			mask_reg <= '0;
		end else if (st_reg == ST_TEACH && st_next == ST_DONE) begin
			mask_reg <= BEAM_BLOCKED & ~N_BEAMS'(1);
		end
	end

	// ***************************
	// outputs and indicators
	// ***************************
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			SAFETY_OUT_A <= 1'b0;
			SAFETY_OUT_B <= 1'b0;
		end else begin
			SAFETY_OUT_A <= st_reg == ST_RUN && !ctrl_inhibit_reg;
			SAFETY_OUT_B <= st_reg == ST_RUN && !ctrl_inhibit_reg;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			STATUS_GREEN <= 1'b0;
			STATUS_RED   <= 1'b0;
			RESET_LED    <= 1'b0;
		end else begin
			STATUS_GREEN <= st_reg == ST_RUN && (!red_res || blink_reg);
			STATUS_RED   <= (st_reg == ST_BLOCK || st_reg == ST_LATCH || st_reg == ST_TEACH)
				|| ((st_reg == ST_DONE || st_reg == ST_LOCK) && blink_reg);
			case (st_reg)
				ST_RUN, ST_BLOCK: RESET_LED <= 1'b1;
				ST_LATCH:         RESET_LED <= bad_any || blink_reg;
				ST_DONE:          RESET_LED <= blink_reg;
				default:          RESET_LED <= 1'b0;
			endcase
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ZONE_GREEN <= '0;
			ZONE_RED   <= '0;
		end else if (st_reg == ST_LOCK || st_reg == ST_START) begin
			ZONE_GREEN <= '0;
			ZONE_RED   <= '0;
		end else if (st_reg == ST_DONE) begin
			ZONE_GREEN <= blink_reg ? zm : '0;
			ZONE_RED   <= '0;
		end else if (BEAM_BLOCKED[0]) begin
			ZONE_GREEN <= '0;
			ZONE_RED   <= N_ZONES'(1);
		end else begin
			ZONE_RED   <= zr;
			ZONE_GREEN <= ~zr & (zm & {N_ZONES{blink_reg}} | ~zm);
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			DISP_MODE  <= DISP_OFF;
			DISP_COUNT <= '0;
		end else begin
			DISP_COUNT <= cnt;
			case (st_reg)
				ST_TEACH: DISP_MODE <= blink_reg ? DISP_TEACH_ACT : bbe_pkg::DISP_COUNT;
				ST_DONE:  DISP_MODE <= DISP_TEACH_DONE;
				ST_LOCK:  DISP_MODE <= DISP_OFF;
				default:  DISP_MODE <= bbe_pkg::DISP_COUNT;
			endcase
		end
	end

	// ***************************
	// AHB-Lite slave, zero wait
	// ***************************
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
			HRDATA      <= '0;
			wr_pend_reg <= 1'b0;
			wa_reg      <= '0;
		end else begin
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
			wr_pend_reg <= HSEL && HTRANS[1] && HREADY && HWRITE;
			wa_reg      <= HADDR[7:0];
			if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
				case (HADDR[7:0])
					`BBE_OFS_CTRL:  HRDATA <= {31'h0, ctrl_inhibit_reg};
					`BBE_OFS_STAT:  HRDATA <= {8'h00, 2'b00, DIP_SW, 8'(cnt), 5'h00, st_reg};
					`BBE_OFS_BLANK: HRDATA <= 32'(mask_reg);
					default:        HRDATA <= 32'h00000000;
				endcase
			end
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctrl_inhibit_reg <= `BBE_CTRL_RST;
		end else if (wr_pend_reg && wa_reg == `BBE_OFS_CTRL) begin
			ctrl_inhibit_reg <= HWDATA[0];
		end
	end

	// ***************************
	// assertions
	// ***************************
	a_out_pair_eq: assert property (@(posedge REF_CLK) disable iff (RESET)
		SAFETY_OUT_A == SAFETY_OUT_B) else $error("safety outputs disagree");
	a_teach_outs_off: assert property (@(posedge REF_CLK) disable iff (RESET)
		(st_reg == ST_TEACH || st_reg == ST_DONE) |=> !SAFETY_OUT_A) else $error("output on in teach");
	a_gap_lockout: assert property (@(posedge REF_CLK) disable iff (RESET)
		(st_reg == ST_RUN && viol) |=> st_reg == ST_LOCK ##1 !SAFETY_OUT_A) else $error("no lockout");
	a_pair_tolerated: assert property (@(posedge REF_CLK) disable iff (RESET)
		(red_res && mask_reg == '0 && cnt == 2 && !BEAM_BLOCKED[0] && |(BEAM_BLOCKED & (BEAM_BLOCKED >> 1)))
		|-> !bad_any) else $error("pair tripped");
	a_green_flash: assert property (@(posedge REF_CLK) disable iff (RESET)
		(st_reg == ST_RUN && red_res && !blink_reg) |=> !STATUS_GREEN) else $error("green steady");
	a_sync_zone: assert property (@(posedge REF_CLK) disable iff (RESET)
		(BEAM_BLOCKED[0] && (st_reg == ST_RUN || st_reg == ST_BLOCK || st_reg == ST_TEACH))
		|=> ZONE_RED == N_ZONES'(1) && ZONE_GREEN == '0) else $error("sync zone wrong");
	a_teach_timeout: assert property (@(posedge REF_CLK) disable iff (RESET)
		(st_reg == ST_TEACH && tmr_reg >= TEACH_LIM) |=> st_reg == ST_LOCK) else $error("teach not timed");
	a_trip_follow: assert property (@(posedge REF_CLK) disable iff (RESET)
		(st_reg == ST_BLOCK && trip && norm_pat && !viol && !bad_any) |=> st_reg == ST_RUN)
		else $error("trip no recover");
	a_latch_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
		(st_reg == ST_LATCH && !rst_ok) |=> st_reg inside {ST_LATCH, ST_LOCK}) else $error("latch left");
	a_count_shown: assert property (@(posedge REF_CLK) disable iff (RESET)
		1'b1 |=> DISP_COUNT == $past(cnt)) else $error("count stale");
	c_teach_done: cover property (@(posedge REF_CLK) st_reg == ST_TEACH ##1 st_reg == ST_DONE);
	c_latch_run: cover property (@(posedge REF_CLK) st_reg == ST_LATCH ##1 st_reg == ST_RUN);
	c_lockout: cover property (@(posedge REF_CLK) st_reg == ST_RUN ##1 st_reg == ST_LOCK);
endmodule

// ### sim/bbe_mach_ctl.sv
`timescale 1ns/1ns
// ***************************
// machine control circuit fed by the safety output pair
// ***************************
module bbe_mach_ctl (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic out_a,
	input  wire logic out_b,
	output logic      motion_on,
	output int        split_count
);
	// motion only while both channels are on; a split pair is a wiring fault
	always_ff @(posedge clk) begin
		if (rst) begin
			motion_on <= 1'b0;
			split_count <= 0;
		end else begin
			motion_on <= out_a & out_b;
			if (out_a !== out_b)
				split_count <= split_count + 1;
		end
	end
endmodule

// ### sim/test_beam_blanking_evaluator.sv
`timescale 1ns/1ns
module test_beam_blanking_evaluator;
	import bbe_pkg::*;
	logic        REF_CLK, RESET, RESET_SW, HSEL, HWRITE, HREADYOUT, HRESP, SAFETY_OUT_A, SAFETY_OUT_B;
	logic        STATUS_GREEN, STATUS_RED, RESET_LED, motion_on;
	logic [15:0] BEAM_BLOCKED;
	logic [5:0]  DIP_SW;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0]  HTRANS;
	logic [3:0]  ZONE_GREEN, ZONE_RED;
	logic [4:0]  DISP_COUNT;
	logic [6:0]  tog;
	bbe_disp_e   DISP_MODE;
	int          fails, samples_checked, split_count, seed, r;
	bbe_top #(.MS_CYCLES(4)) uut (.REF_CLK(REF_CLK), .RESET(RESET), .BEAM_BLOCKED(BEAM_BLOCKED),
		.DIP_SW(DIP_SW), .RESET_SW(RESET_SW), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
		.HRDATA(HRDATA), .HRESP(HRESP), .SAFETY_OUT_A(SAFETY_OUT_A), .SAFETY_OUT_B(SAFETY_OUT_B),
		.STATUS_GREEN(STATUS_GREEN), .STATUS_RED(STATUS_RED), .RESET_LED(RESET_LED),
		.ZONE_GREEN(ZONE_GREEN), .ZONE_RED(ZONE_RED), .DISP_MODE(DISP_MODE), .DISP_COUNT(DISP_COUNT));
	bbe_mach_ctl mach (.clk(REF_CLK), .rst(RESET), .out_a(SAFETY_OUT_A), .out_b(SAFETY_OUT_B),
		.motion_on(motion_on), .split_count(split_count));
	// ***************************
	// reference model
	// ***************************
	function automatic int exp_on(input logic [15:0] b, input int red_res);
		int run;
		int ok;
		run = 0;
		ok = !b[0];
		for (int i = 1; i < 16; i++) begin
			run = b[i] ? run + 1 : 0;
			if (run > (red_res ? 2 : 0))
				ok = 0;
		end
		return ok;
	endfunction
	function automatic logic [31:0] exp_zone(input logic [15:0] b);
		logic [31:0] z;
		z = 32'h0;
		for (int i = 0; i < 16; i++)
			if (b[i])
				z[i / 4] = 1'b1;
		return b[0] ? 32'h1 : z;
	endfunction
	// ***************************
	// tasks
	// ***************************
	task automatic print_verdict();
		$display("counts: %0d checked, %0d wrong", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge REF_CLK);
			k++;
		end while (HREADYOUT !== 1'b1 && k < 50);
		if (k >= 50) begin
			fails++;
			print_verdict();
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= a;
		HWRITE <= wr;
		rdy();
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= wd;
		rdy();
		rd = HRDATA;
		cmp({31'h0, HRESP}, 32'h0, "response");
	endtask
	task automatic do_reset(input logic [5:0] sw);
		DIP_SW <= sw;
		RESET <= 1'b1;
		tick(10);
		RESET <= 1'b0;
		tick(6);
	endtask
	task automatic press(input int n);
		RESET_SW <= 1'b1;
		tick(n);
		RESET_SW <= 1'b0;
		tick(6);
	endtask
	task automatic beams(input logic [15:0] b);
		BEAM_BLOCKED <= b;
		tick(5);
	endtask
	// collects which of {DISP_MODE, STATUS_GREEN, ZONE_GREEN} changed within 2200 cycles, about 1.1 blink periods
	task automatic toggles();
		logic [6:0] o, a;
		o = 7'h00;
		a = 7'h7F;
		repeat (2200) begin
			@(posedge REF_CLK);
			o = o | {DISP_MODE, STATUS_GREEN, ZONE_GREEN};
			a = a & {DISP_MODE, STATUS_GREEN, ZONE_GREEN};
		end
		tog = o & ~a;
	endtask
	// ***************************
	// stimulus
	// ***************************
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end
	initial begin
		#400000;
		fails++;
		print_verdict();
	end
	initial begin
		{RESET, RESET_SW, HSEL, HWRITE, HTRANS, HADDR, HWDATA, BEAM_BLOCKED} = '0;
		DIP_SW = 6'h00;
		seed = 32'h55F5;
		fails = 0;
		samples_checked = 0;
		do_reset(6'b010100);
		for (int i = 0; i < 10; i++) begin
			r = $random(seed);
			beams((16'h1 << r[3:0]) | (r[8] ? 16'h1 << r[7:4] : 16'h0));
			cmp(SAFETY_OUT_A, exp_on(BEAM_BLOCKED, 0), "trip out");
			cmp(ZONE_RED, exp_zone(BEAM_BLOCKED), "zone red");
			cmp(DISP_COUNT, $countones(BEAM_BLOCKED), "count");
			beams(16'h0);
			cmp(SAFETY_OUT_A, 1, "trip recover");
		end
		ahb(1'b1, 32'h00, 32'h1);
		tick(4);
		cmp(SAFETY_OUT_A, 0, "inhibit");
		ahb(1'b0, 32'h0C, 32'h0);
		cmp(rd, 32'h0, "unmapped");
		ahb(1'b1, 32'h00, 32'h0);
		$display("done: trip mode and bus");
		do_reset(6'b011110);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			beams((r[0] ? 16'h3 : 16'h7) << (1 + r[7:4] % 13));
			cmp(SAFETY_OUT_A, exp_on(BEAM_BLOCKED, 1), "reduced res");
		end
		beams(16'h0);
		toggles();
		cmp(tog, 7'h10, "green flash");
		$display("done: reduced resolution");
		do_reset(6'b000110);
		ahb(1'b0, 32'h04, 32'h0);
		cmp(rd[2:0], 4, "teach at power-up");
		beams(16'h0B05);
		cmp({SAFETY_OUT_A, STATUS_RED, RESET_LED}, 3'b010, "teach leds");
		cmp(DISP_COUNT, 5, "teach count");
		toggles();
		cmp(tog[6:5], 2'b01, "teach display alternates");
		DIP_SW <= 6'b010100;
		tick(6);
		cmp(DISP_MODE, DISP_TEACH_DONE, "done code");
		cmp(SAFETY_OUT_A, 0, "done out");
		ahb(1'b0, 32'h08, 32'h0);
		cmp(rd, 32'h0B04, "taught mask");
		beams(16'h0B04);
		press(2000);
		cmp(SAFETY_OUT_A, 1, "run with blanked");
		toggles();
		cmp(tog, 7'h05, "blanked zones flash");
		beams(16'h0A04);
		cmp(SAFETY_OUT_A, 0, "blank removed");
		ahb(1'b0, 32'h04, 32'h0);
		cmp(rd[2:0], 6, "lockout");
		$display("done: fixed blanking");
		DIP_SW <= 6'b000110;
		beams(16'h0);
		press(2000);
		ahb(1'b0, 32'h04, 32'h0);
		cmp(rd[2:0], 4, "teach from lockout");
		DIP_SW <= 6'b010100;
		tick(6);
		ahb(1'b0, 32'h08, 32'h0);
		cmp(rd, 32'h0, "empty mask");
		press(2000);
		cmp(SAFETY_OUT_A, 1, "run clear");
		$display("done: blanking cleared");
		do_reset(6'b000000);
		cmp(SAFETY_OUT_A, 0, "latch start");
		press(2000);
		cmp(SAFETY_OUT_A, 1, "latch reset");
		beams(16'h0008);
		beams(16'h0000);
		cmp({SAFETY_OUT_A, STATUS_RED}, 2'b01, "latch hold");
		press(2000);
		cmp(SAFETY_OUT_A, 1, "latch rearm");
		cmp(split_count, 0, "pair split");
		cmp(motion_on, 1, "machine motion");
		$display("done: latch mode");
		print_verdict();
	end
endmodule
